/* bench/mfpm_host.sv */
/*
  Host processor model: a classic Wishbone master for the pin multiplexer.
  Assumes one clock shared with the slave and a registered one-cycle ack.
*/
`timescale 1ns/1ps
module mfpm_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] wdat_o
);
  // Idle bus from time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    wdat_o = 32'h0000_0000;
  end

  // ----------------------------------------------------------------------
  // One classic cycle; all four byte lanes selected, cyc and stb dropped after the ack
  // ----------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    wdat_o <= d;
    // Ack and data are read at the rising edge, before the slave moves
    // them; only the bench watchdog ends a wait that gets no answer
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
  endtask
endmodule

/* bench/tb_top.sv */
/*
  Self-checking bench for the pin and clock multiplexer.
  Assumes the host model in mfpm_host.sv and the design package headers.
*/
`timescale 1ns/1ps
`include "mfpm_defines.svh"
module tb_top;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] k;
    logic [7:0] e;
  } mfpm_row_t;

  logic clk_i, rst_n_i, cyc, stb, we, ack, spi, first_interrupt_output;
  logic [7:0] adr;
  logic [3:0] sel, pins;
  logic [31:0] wd, rd, q;
  logic bus_spi, pll_ref, cod_clk, pll_en, abclk, f_o, f_oe_n, gpi;
  logic irq1, irq2, lb, rb, lm, rm, hi;
  logic [4:0] pwr;
  logic [6:0] latt, ratt;
  logic [7:0] llvl, rlvl;
  logic [1:0] cm;
  int num_errors = 0;
  int samples_checked = 0;
  int c;

  // Each row: write one register, then look at one group of outputs
  mfpm_row_t rows [0:18] = '{
    '{`MFPM_REG_POWER, 32'h0F, 4'd0, 8'h0F},
    '{`MFPM_REG_POWER, 32'h17, 4'd0, 8'h13},
    '{`MFPM_REG_ROUTE, 32'h0F, 4'd1, 8'h0C},
    '{`MFPM_REG_POWER, 32'h03, 4'd1, 8'h0F},
    '{`MFPM_REG_ROUTE, 32'h4800_4800, 4'd2, 8'h48},
    '{`MFPM_REG_ROUTE, 32'h7F00_7F00, 4'd3, 8'h48},
    '{`MFPM_REG_HPLVL, 32'h3F, 4'd4, 8'h23},
    '{`MFPM_REG_HPLVL, 32'h01, 4'd4, 8'h01},
    '{`MFPM_REG_HPLVL, 32'h81, 4'd4, 8'h81},
    '{`MFPM_REG_ROUTE, 32'h0004_0000, 4'd5, 8'h00},
    '{`MFPM_REG_ROUTE, 32'h0005_0000, 4'd5, 8'h01},
    '{`MFPM_REG_ROUTE, 32'h0006_0000, 4'd5, 8'h02},
    '{`MFPM_REG_ROUTE, 32'h0007_0000, 4'd5, 8'h02},
    '{`MFPM_REG_ROUTE, 32'h0006_0000, 4'd6, 8'h01},
    '{`MFPM_REG_PINFN, 32'h01, 4'd8, 8'h00},
    '{`MFPM_REG_GPIO, 32'h01, 4'd10, 8'h01},
    '{`MFPM_REG_PINFN, 32'h01, 4'd7, 8'h00},
    '{`MFPM_REG_PINFN, 32'h03, 4'd7, 8'h01},
    '{`MFPM_REG_CLKSRC, 32'h30, 4'd9, 8'h01}
  };

  mfpm_top u_mfpm_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .spi_select_i(spi),
    .master_clk_i(pins[0]), .bit_clk_i(pins[1]), .data_in_i(pins[2]),
    .fifth_pin_i(pins[3]), .first_interrupt_output_evt_i(first_interrupt_output), .second_interrupt_output_evt_i(1'b0),
    .gpo_val_i(1'b0), .aux_clk_i(1'b0), .bus_is_spi_o(bus_spi),
    .pll_ref_o(pll_ref), .codec_clk_o(cod_clk), .pll_clk_i_en_o(pll_en),
    .audio_bclk_o(abclk), .fifth_pin_o(f_o), .fifth_pin_oe_n_o(f_oe_n),
    .gpi_o(gpi), .first_interrupt_output_o(irq1),
    .second_interrupt_output_o(irq2), .power_en_o(pwr),
    .left_bypass_en_o(lb), .right_bypass_en_o(rb), .left_dac_mix_o(lm),
    .right_dac_mix_o(rm), .left_att_o(latt), .right_att_o(ratt),
    .left_hp_lvl_o(llvl), .right_hp_lvl_o(rlvl), .hp_cm_o(cm),
    .hp_hi_supply_o(hi));

  mfpm_host u_mfpm_host (.clk_i(clk_i), .ack_i(ack), .rdat_i(rd),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .wdat_o(wd));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  function automatic logic [7:0] obs(input logic [3:0] k);
    case (k)
      4'd0: obs = {3'h0, pwr};
      4'd1: obs = {4'h0, lb, rb, lm, rm};
      4'd2: obs = {1'b0, latt};
      4'd3: obs = {1'b0, ratt};
      4'd4: obs = llvl;
      4'd5: obs = {6'h00, cm};
      4'd6: obs = {7'h00, hi};
      4'd7: obs = {7'h00, irq1};
      4'd8: obs = {7'h00, f_oe_n};
      4'd10: obs = {7'h00, f_o};
      default: obs = {7'h00, pll_en};
    endcase
  endfunction

  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Watchdog far beyond the two hundred or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    spi = 1'b0;
    first_interrupt_output = 1'b1;
    pins = 4'h0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk({31'h0, f_oe_n}, 32'h1);
    chk({27'h0, pwr}, 32'h0);
    foreach (rows[i]) begin
      u_mfpm_host.xfer(1'b1, rows[i].a, rows[i].d, q);
      repeat (2) @(posedge clk_i);
      chk({24'h0, obs(rows[i].k)}, {24'h0, rows[i].e});
    end
    // Protocol pin follows its level whatever the registers hold
    for (int v = 0; v < 2; v++) begin
      spi <= v[0];
      repeat (5) @(posedge clk_i);
      chk({31'h0, bus_spi}, v);
    end
    // Unmapped place: write dropped, reads zero
    u_mfpm_host.xfer(1'b1, 8'h40, 32'hFFFF_FFFF, q);
    u_mfpm_host.xfer(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    u_mfpm_host.xfer(1'b1, `MFPM_REG_PINFN, 32'h10, q);
    // Each pin as reference, shared with the converter clock where legal
    for (int s = 0; s < 4; s++) begin
      c = (s == 2) ? 3 : (s == 3) ? 2 : s;
      u_mfpm_host.xfer(1'b1, `MFPM_REG_CLKSRC, 32'(s + c * 16), q);
      for (int p = 0; p < 2; p++) begin
        pins <= (p == 1) ? (4'h1 << s) : ~(4'h1 << s);
        repeat (5) @(posedge clk_i);
        chk({31'h0, pll_ref}, p);
        chk({31'h0, cod_clk}, (c != 3) ? p : 0);
        if (s == 1) chk({31'h0, abclk}, p);
      end
    end
    // Pin taken as general output, then reset in mid-run restores it
    u_mfpm_host.xfer(1'b1, `MFPM_REG_PINFN, 32'h11, q);
    @(posedge clk_i);
    chk({31'h0, f_oe_n}, 32'h0);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk({27'h0, pwr}, 32'h0);
    chk({31'h0, f_oe_n}, 32'h1);
    u_mfpm_host.xfer(1'b0, `MFPM_REG_CLKSRC, 32'h0, q);
    chk(q, `MFPM_RST_CLKSRC);
    u_mfpm_host.xfer(1'b0, `MFPM_REG_PINFN, 32'h0, q);
    chk(q, `MFPM_RST_PINFN);
    end_sim();
  end
endmodule

/* common/mfpm_defines.svh */
/*
  Constants for the pin and clock multiplexer: register offsets, field
  positions, reset values and level codes.
  Assumes inclusion by bare name from the design top and the bench.
*/
// What this block does
// - Select pin level picks I2C or SPI use of the two bus pins
// - Reset and protocol select pins are fixed; no register reassigns them
// - Other digital pins start at defaults, reassignable by register
// - PLL reference picks one of four pins by register
// - Converter clock comes from master, bit clock, fifth pin or PLL
// - Master clock pin may feed PLL and converter clock together
// - Bit clock pin may feed PLL, converter clock and audio bit clock
// - Fifth pin may feed PLL and converter clock together
// - An exclusive function owns its pin; nothing else routed there (clock selects still read the fifth pin in any function)
// - Fifth pin as general output is never also first interrupt
// - All analog blocks powered down after reset, each up by register
// - Bypass routes left input to left driver, right to right, DAC off
// - Each driver takes a mix of DAC and bypassed input
// - Bypassed input attenuation reaches 72dB
// - Driver level spans minimum up to +29dB in 1dB steps
// - Common mode selectable 1.25V, 1.5V, 1.65V on regulator supply
`ifndef MFPM_DEFINES_SVH
`define MFPM_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define MFPM_REG_CLKSRC 8'h00
`define MFPM_REG_PINFN 8'h04
`define MFPM_REG_POWER 8'h08
`define MFPM_REG_ROUTE 8'h0C
`define MFPM_REG_HPLVL 8'h10
`define MFPM_REG_STATUS 8'h14
`define MFPM_REG_GPIO 8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MFPM_CLK_PLL_LSB 0
`define MFPM_CLK_COD_LSB 4
`define MFPM_PIN_FIFTH_LSB 0
`define MFPM_PIN_BCLK_LSB 4
`define MFPM_PIN_DOUT_LSB 8
`define MFPM_PWR_HPL_BIT 0
`define MFPM_PWR_HPR_BIT 1
`define MFPM_PWR_DAC_BIT 2
`define MFPM_PWR_PLL_BIT 3
`define MFPM_PWR_BYP_BIT 4
`define MFPM_RT_CM_LSB 16
`define MFPM_RT_SUPPLY_BIT 18
`define MFPM_HP_MUTE_BIT 7

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define MFPM_RST_CLKSRC 32'h0000_0000
`define MFPM_RST_PINFN 32'h0000_0010
`define MFPM_RST_POWER 5'h00
`define MFPM_RST_ROUTE 32'h0000_0000
`define MFPM_RST_HPLVL 8'h00
`define MFPM_ATT_MAX 7'h48
`define MFPM_LVL_MIN (-6)
`define MFPM_LVL_MAX 29
`define MFPM_LVL_STEP 1
`define MFPM_LVL_CODE_MAX 6'h23
`define MFPM_LVL_CODE_M5 6'h01
`define MFPM_LVL_CODE_MIN 6'h00

`endif

/* common/mfpm_pkg.sv */
/*
  Types for the pin and clock multiplexer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mfpm_pkg;

  // ----------------------------------------------------------------------
  // Clock source choices
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MFPM_SRC_MCLK = 2'h0,
    MFPM_SRC_BCLK = 2'h1,
    MFPM_SRC_DIN = 2'h2,
    MFPM_SRC_FIFTH = 2'h3
  } mfpm_pll_src_t;

  typedef enum logic [1:0] {
    MFPM_COD_MCLK = 2'h0,
    MFPM_COD_BCLK = 2'h1,
    MFPM_COD_FIFTH = 2'h2,
    MFPM_COD_PLL = 2'h3
  } mfpm_cod_src_t;

  // ----------------------------------------------------------------------
  // Fifth multifunction pin functions
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MFPM_FN_CLKIN = 3'h0,
    MFPM_FN_GPO = 3'h1,
    MFPM_FN_GPI = 3'h2,
    MFPM_FN_FIRST_INTERRUPT_OUTPUT = 3'h3,
    MFPM_FN_SECOND_INTERRUPT_OUTPUT = 3'h4,
    MFPM_FN_AUXCLK = 3'h5
  } mfpm_fifth_fn_t;

  // Common-mode choices on the regulator input supply
  typedef enum logic [1:0] {
    MFPM_CM_1V25 = 2'h0,
    MFPM_CM_1V50 = 2'h1,
    MFPM_CM_1V65 = 2'h2
  } mfpm_cm_t;

endpackage

/* hdl/mfpm_sync.sv */
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous to clk_i.
*/
`timescale 1ns/1ps
module mfpm_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;

  // ----------------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------------
  // First stage is read by the second stage only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

/* hdl/mfpm_top.sv */
/*
  Pin-function and clock-source multiplexer with Wishbone registers.
  Assumes a classic Wishbone master on clk_i; pin clocks are treated as
  plain levels, resampled on clk_i and routed by selection.
*/
`timescale 1ns/1ps
`include "mfpm_defines.svh"
module mfpm_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic spi_select_i,
  input wire logic master_clk_i,
  input wire logic bit_clk_i,
  input wire logic data_in_i,
  input wire logic fifth_pin_i,
  input wire logic first_interrupt_output_evt_i,
  input wire logic second_interrupt_output_evt_i,
  input wire logic gpo_val_i,
  input wire logic aux_clk_i,
  output logic bus_is_spi_o,
  output logic pll_ref_o,
  output logic codec_clk_o,
  output logic pll_clk_i_en_o,
  output logic audio_bclk_o,
  output logic fifth_pin_o,
  output logic fifth_pin_oe_n_o,
  output logic gpi_o,
  output logic first_interrupt_output_o,
  output logic second_interrupt_output_o,
  output logic [4:0] power_en_o,
  output logic left_bypass_en_o,
  output logic right_bypass_en_o,
  output logic left_dac_mix_o,
  output logic right_dac_mix_o,
  output logic [6:0] left_att_o,
  output logic [6:0] right_att_o,
  output logic [7:0] left_hp_lvl_o,
  output logic [7:0] right_hp_lvl_o,
  output logic [1:0] hp_cm_o,
  output logic hp_hi_supply_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [4:0] pin_s, power_r;
  logic sel_s, mclk_s, bclk_s, din_s, fifth_s;
  mfpm_pkg::mfpm_pll_src_t pll_src_r;
  mfpm_pkg::mfpm_cod_src_t cod_src_r;
  mfpm_pkg::mfpm_fifth_fn_t fifth_fn_r;
  logic bclk_as_audio_r, dout_second_interrupt_output_r;
  logic [31:0] route_r, rd_nxt;
  logic [7:0] hpl_r, hpr_r;
  logic gpo_r, fifth_drv_nxt, fifth_oe_n_nxt, bus_hit;
  default clocking cb_chk @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Clamp a requested bypass attenuation to the 72dB floor
  function automatic logic [6:0] clamp_att(input logic [6:0] v);
    clamp_att = (v > `MFPM_ATT_MAX) ? `MFPM_ATT_MAX : v;
  endfunction
  // Clamp a level code to the +29dB top; bit 7 is the mute flag
  function automatic logic [7:0] clamp_lvl(input logic [7:0] v);
    logic [5:0] c;
    c = (v[5:0] > `MFPM_LVL_CODE_MAX) ? `MFPM_LVL_CODE_MAX : v[5:0];
    clamp_lvl = {v[`MFPM_HP_MUTE_BIT], 1'b0, c};
  endfunction
  // Byte-lane merge for Wishbone sel
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Pins are asynchronous, so every one passes two flops first
  mfpm_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({spi_select_i, master_clk_i, bit_clk_i, data_in_i, fifth_pin_i}),
    .q_o(pin_s)
  );
  assign {sel_s, mclk_s, bclk_s, din_s, fifth_s} = pin_s;

  // ----------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------
  assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // One-cycle ack, dropped the cycle after; unmapped reads give zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_hit;
      wb_dat_o <= bus_hit ? rd_nxt : 32'h0000_0000;
    end
  end

  // Read mux; the status word mirrors live state
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (wb_adr_i)
      `MFPM_REG_CLKSRC: begin
        rd_nxt[`MFPM_CLK_PLL_LSB +: 2] = pll_src_r;
        rd_nxt[`MFPM_CLK_COD_LSB +: 2] = cod_src_r;
      end
      `MFPM_REG_PINFN: begin
        rd_nxt[`MFPM_PIN_FIFTH_LSB +: 3] = fifth_fn_r;
        rd_nxt[`MFPM_PIN_BCLK_LSB] = bclk_as_audio_r;
        rd_nxt[`MFPM_PIN_DOUT_LSB] = dout_second_interrupt_output_r;
      end
      `MFPM_REG_POWER: rd_nxt[4:0] = power_r;
      `MFPM_REG_ROUTE: rd_nxt = route_r;
      `MFPM_REG_HPLVL: rd_nxt[15:0] = {hpr_r, hpl_r};
      `MFPM_REG_STATUS: rd_nxt[4:0] = pin_s;
      `MFPM_REG_GPIO: rd_nxt[0] = gpo_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Clock source registers
  // ----------------------------------------------------------------------
  // Async reset restores defaults whenever reset asserts
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_src_r <= mfpm_pkg::MFPM_SRC_MCLK;
      cod_src_r <= mfpm_pkg::MFPM_COD_MCLK;
    end else if (bus_hit && wb_we_i && wb_adr_i == `MFPM_REG_CLKSRC &&
                 wb_sel_i[0]) begin
      pll_src_r <= mfpm_pkg::mfpm_pll_src_t'(
        wb_dat_i[`MFPM_CLK_PLL_LSB +: 2]);
      cod_src_r <= mfpm_pkg::mfpm_cod_src_t'(
        wb_dat_i[`MFPM_CLK_COD_LSB +: 2]);
    end
  end

  // ----------------------------------------------------------------------
  // Pin function registers
  // ----------------------------------------------------------------------
  // Only a legal code is accepted; anything else keeps the old function
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fifth_fn_r <= mfpm_pkg::MFPM_FN_CLKIN;
      bclk_as_audio_r <= 1'b1;
      dout_second_interrupt_output_r <= 1'b0;
    end else if (bus_hit && wb_we_i && wb_adr_i == `MFPM_REG_PINFN) begin
      if (wb_sel_i[0]) begin
        if (wb_dat_i[2:0] <= 3'h5) begin
          fifth_fn_r <= mfpm_pkg::mfpm_fifth_fn_t'(wb_dat_i[2:0]);
        end
        bclk_as_audio_r <= wb_dat_i[`MFPM_PIN_BCLK_LSB];
      end
      if (wb_sel_i[1]) begin
        dout_second_interrupt_output_r <= wb_dat_i[`MFPM_PIN_DOUT_LSB];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power, routing, level and output registers
  // ----------------------------------------------------------------------
  // All analog blocks start off; software powers each one up
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_r <= `MFPM_RST_POWER;
      route_r <= `MFPM_RST_ROUTE;
      hpl_r <= `MFPM_RST_HPLVL;
      hpr_r <= `MFPM_RST_HPLVL;
      gpo_r <= 1'b0;
    end else if (bus_hit && wb_we_i) begin
      unique case (wb_adr_i)
        `MFPM_REG_POWER: begin
          if (wb_sel_i[0]) begin
            power_r <= wb_dat_i[4:0];
          end
        end
        `MFPM_REG_ROUTE: route_r <= merge(route_r, wb_dat_i, wb_sel_i);
        `MFPM_REG_HPLVL: begin
          // Levels are meant to be set once during setup
          if (wb_sel_i[0]) begin
            hpl_r <= clamp_lvl(wb_dat_i[7:0]);
          end
          if (wb_sel_i[1]) begin
            hpr_r <= clamp_lvl(wb_dat_i[15:8]);
          end
        end
        `MFPM_REG_GPIO: begin
          if (wb_sel_i[0]) begin
            gpo_r <= wb_dat_i[0];
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Fifth pin driver
  // ----------------------------------------------------------------------
  // One function at a time: the enum holds a single owner per pin
  always_comb begin
    fifth_drv_nxt = 1'b0;
    fifth_oe_n_nxt = 1'b1;
    unique case (fifth_fn_r)
      mfpm_pkg::MFPM_FN_GPO: begin
        fifth_drv_nxt = gpo_r | gpo_val_i;
        fifth_oe_n_nxt = 1'b0;
      end
      mfpm_pkg::MFPM_FN_FIRST_INTERRUPT_OUTPUT: begin
        fifth_drv_nxt = first_interrupt_output_evt_i;
        fifth_oe_n_nxt = 1'b0;
      end
      mfpm_pkg::MFPM_FN_SECOND_INTERRUPT_OUTPUT: begin
        fifth_drv_nxt = second_interrupt_output_evt_i;
        fifth_oe_n_nxt = 1'b0;
      end
      mfpm_pkg::MFPM_FN_AUXCLK: begin
        fifth_drv_nxt = aux_clk_i;
        fifth_oe_n_nxt = 1'b0;
      end
      default: ; // Clock or general input: pin left undriven
    endcase
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  // Bus mode follows the select pin only; no register can override it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_is_spi_o <= 1'b0;
    end else begin
      bus_is_spi_o <= sel_s;
    end
  end

  // Clock routing; one pin may fan out to several clock users at once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_ref_o <= 1'b0;
      codec_clk_o <= 1'b0;
      audio_bclk_o <= 1'b0;
      pll_clk_i_en_o <= 1'b0;
    end else begin
      unique case (pll_src_r)
        mfpm_pkg::MFPM_SRC_MCLK: pll_ref_o <= mclk_s;
        mfpm_pkg::MFPM_SRC_BCLK: pll_ref_o <= bclk_s;
        mfpm_pkg::MFPM_SRC_DIN: pll_ref_o <= din_s;
        mfpm_pkg::MFPM_SRC_FIFTH: pll_ref_o <= fifth_s;
      endcase
      unique case (cod_src_r)
        mfpm_pkg::MFPM_COD_MCLK: codec_clk_o <= mclk_s;
        mfpm_pkg::MFPM_COD_BCLK: codec_clk_o <= bclk_s;
        mfpm_pkg::MFPM_COD_FIFTH: codec_clk_o <= fifth_s;
        mfpm_pkg::MFPM_COD_PLL: codec_clk_o <= 1'b0;
      endcase
      audio_bclk_o <= bclk_as_audio_r & bclk_s;
      pll_clk_i_en_o <= (cod_src_r == mfpm_pkg::MFPM_COD_PLL);
    end
  end

  // Fifth pin, interrupt and general input outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fifth_pin_o <= 1'b0;
      fifth_pin_oe_n_o <= 1'b1;
      gpi_o <= 1'b0;
      first_interrupt_output_o <= 1'b0;
      second_interrupt_output_o <= 1'b0;
    end else begin
      fifth_pin_o <= fifth_drv_nxt;
      fifth_pin_oe_n_o <= fifth_oe_n_nxt;
      gpi_o <= (fifth_fn_r == mfpm_pkg::MFPM_FN_GPI) & fifth_s;
      // Never first interrupt while the pin is a general output
      first_interrupt_output_o <= (fifth_fn_r == mfpm_pkg::MFPM_FN_FIRST_INTERRUPT_OUTPUT) &
                                  first_interrupt_output_evt_i;
      second_interrupt_output_o <= dout_second_interrupt_output_r & second_interrupt_output_evt_i;
    end
  end

  // Analog power and routing; bypass forces DAC off to save power
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_en_o <= 5'h00;
      left_bypass_en_o <= 1'b0;
      right_bypass_en_o <= 1'b0;
      left_dac_mix_o <= 1'b0;
      right_dac_mix_o <= 1'b0;
      left_att_o <= 7'h00;
      right_att_o <= 7'h00;
      left_hp_lvl_o <= 8'h00;
      right_hp_lvl_o <= 8'h00;
      hp_cm_o <= 2'h0;
      hp_hi_supply_o <= 1'b0;
    end else begin
      power_en_o <= power_r[`MFPM_PWR_BYP_BIT] ?
        (power_r & ~(5'h01 << `MFPM_PWR_DAC_BIT)) : power_r;
      left_bypass_en_o <= route_r[0] | power_r[`MFPM_PWR_BYP_BIT];
      right_bypass_en_o <= route_r[1] | power_r[`MFPM_PWR_BYP_BIT];
      left_dac_mix_o <= route_r[2] & !power_r[`MFPM_PWR_BYP_BIT];
      right_dac_mix_o <= route_r[3] & !power_r[`MFPM_PWR_BYP_BIT];
      left_att_o <= clamp_att(route_r[14:8]);
      right_att_o <= clamp_att(route_r[30:24]);
      left_hp_lvl_o <= hpl_r;
      right_hp_lvl_o <= hpr_r;
      hp_hi_supply_o <= route_r[`MFPM_RT_SUPPLY_BIT];
      // Code 3 is not a common mode; treat as 1.65V
      hp_cm_o <= (route_r[`MFPM_RT_CM_LSB +: 2] == 2'h3) ?
        mfpm_pkg::MFPM_CM_1V65 : route_r[`MFPM_RT_CM_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // Master pin feeds both clock users, PLL selection held one more cycle
  sequence s_mclk_shared;
    pll_src_r == mfpm_pkg::MFPM_SRC_MCLK &&
      cod_src_r == mfpm_pkg::MFPM_COD_MCLK ##1 $stable(pll_src_r);
  endsequence
  a_first_interrupt_output_excl_gpo: assert property (
    $past(fifth_fn_r) == mfpm_pkg::MFPM_FN_GPO |-> !first_interrupt_output_o)
    else $error("interrupt on pin used as output");
  a_bus_mode_follow: assert property (bus_is_spi_o == $past(sel_s))
    else $error("bus mode not following select");
  a_bypass_dac_off: assert property (
    $past(power_r[`MFPM_PWR_BYP_BIT]) |-> !power_en_o[`MFPM_PWR_DAC_BIT] &&
      left_bypass_en_o && right_bypass_en_o)
    else $error("bypass left DAC powered");
  a_att_bound: assert property (
    left_att_o <= `MFPM_ATT_MAX && right_att_o <= `MFPM_ATT_MAX)
    else $error("attenuation above limit");
  a_level_bound: assert property (
    left_hp_lvl_o[5:0] <= `MFPM_LVL_CODE_MAX &&
      right_hp_lvl_o[5:0] <= `MFPM_LVL_CODE_MAX)
    else $error("level above top step");
  a_pll_route_mclk: assert property (
    s_mclk_shared |-> pll_ref_o == codec_clk_o)
    else $error("master clock fan-out split");
  a_fifth_excl: assert property (
    $past(fifth_fn_r) == mfpm_pkg::MFPM_FN_GPI |-> fifth_pin_oe_n_o)
    else $error("input pin driven");
  a_cm_legal: assert property (hp_cm_o != 2'h3)
    else $error("illegal common mode");

endmodule
